// >>> pc_stack_pkg.sv
// Shared constants, register map and operation codes of the program counter and return stack.
package pc_stack_pkg;

   localparam int PC_WIDTH          = 21;
   localparam int PTR_WIDTH         = 5;
   localparam int STACK_DEPTH       = 31;
   localparam int DATA_WIDTH        = 32;
   localparam int ADDR_WIDTH        = 4;

   localparam logic [20:0] RESET_VECTOR     = 21'h000000;
   localparam logic [20:0] HIGH_VECTOR      = 21'h000008;
   localparam logic [20:0] LOW_VECTOR       = 21'h000018;
   localparam logic [20:0] PC_STEP          = 21'h000002;
   localparam logic [4:0]  PTR_RESET        = 5'h00;
   localparam logic [4:0]  PTR_FULL         = 5'h1f;
   localparam logic [4:0]  PTR_ONE          = 5'h01;

   // Word addresses of the register words on the bus.
   localparam logic [3:0] OFS_STACK_PTR    = 4'h0;
   localparam logic [3:0] OFS_TOP_LOW      = 4'h1;
   localparam logic [3:0] OFS_TOP_HIGH     = 4'h2;
   localparam logic [3:0] OFS_TOP_UPPER    = 4'h3;
   localparam logic [3:0] OFS_PC_LOW       = 4'h4;
   localparam logic [3:0] OFS_PC_HIGH_LAT  = 4'h5;
   localparam logic [3:0] OFS_PC_UPPER_LAT = 4'h6;
   localparam logic [3:0] OFS_CONTROL      = 4'h7;
   localparam logic [3:0] OFS_PC_FULL      = 4'h8;

   localparam int BIT_FULL        = 7;
   localparam int BIT_UNDERFLOW   = 6;
   localparam int BIT_FAULT_RST   = 0;
   localparam logic CONTROL_RESET = 1'b1;

   // Core clock divided into four phases per instruction cycle.
   localparam logic [1:0] PHASE_Q1  = 2'h0;
   localparam logic [1:0] PHASE_MAX = 2'h3;

   typedef enum logic [3:0] {
      OP_NONE      = 4'b0000,
      OP_CALL      = 4'b0001,
      OP_RELATIVE_CALL     = 4'b0010,
      OP_GOTO      = 4'b0011,
      OP_RETURN    = 4'b0100,
      OP_RETURN_WITH_LITERAL     = 4'b0101,
      OP_RETURN_FROM_INTERRUPT    = 4'b0110,
      OP_INT_HIGH  = 4'b0111,
      OP_INT_LOW   = 4'b1000,
      OP_PUSH      = 4'b1001,
      OP_POP       = 4'b1010
   } core_op_t;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] working;
      logic [7:0] bank;
   } fast_regs_t;

   typedef struct packed {
      core_op_t    op;
      logic        fast;
      logic [20:0] target;
   } core_req_t;

endpackage : pc_stack_pkg

// >>> pc_and_return_stack.sv
// Program counter, return address stack and fast shadow registers of the core.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pc_and_return_stack #(
   parameter int         MEM_BYTES = 8192
) (
   input  wire logic                        clk_in,
   input  wire logic                        rst_n_in,
   input  wire logic                        por_n_in,
   input  wire logic                        fault_cfg_in,
   input  wire pc_stack_pkg::core_req_t     req_in,
   input  wire pc_stack_pkg::fast_regs_t    regs_in,
   input  wire logic [15:0]                 fetch_word_in,
   input  wire logic [3:0]                  avs_address_in,
   input  wire logic                        avs_read_in,
   input  wire logic                        avs_write_in,
   input  wire logic [31:0]                 avs_writedata_in,
   input  wire logic [3:0]                  avs_byteenable_in,
   output logic [31:0]                      avs_readdata_out,
   output logic                             avs_waitrequest_out,
   output logic [20:0]                      pc_out,
   output logic [15:0]                      fetch_word_out,
   output logic                             phase_q1_out,
   output logic                             fast_restore_out,
   output pc_stack_pkg::fast_regs_t         fast_regs_out,
   output logic                             stack_reset_out
);

   logic [20:0]               stack_mem [1:pc_stack_pkg::STACK_DEPTH];
   logic [20:0]               pc_r;
   logic [7:0]                high_latch_r;
   logic [4:0]                upper_latch_r;
   logic [4:0]                ptr_r;
   logic [4:0]                ptr_nxt;
   logic                      full_r;
   logic                      underflow_r;
   logic                      fault_en_r;
   logic [1:0]                phase_r;
   logic                      q1;
   logic                      bus_ack_r;
   logic                      fault_reset_r;
   pc_stack_pkg::fast_regs_t  shadow_r;
   logic                      push;
   logic                      pop_ret;
   logic                      pop_discard;
   logic                      hw_ptr_op;
   logic                      wr_go;
   logic                      rd_go;
   logic                      pcl_wr;
   logic [20:0]               top_value;
   logic [20:0]               push_value;
   logic                      stack_is_full;

   // Pointer value zero has no storage behind it, so its top reads as zero.
   function automatic logic [20:0] read_entry(input logic [4:0] p, input logic [20:0] v);
      read_entry = (p == pc_stack_pkg::PTR_RESET) ? 21'h000000 : v;
   endfunction : read_entry

   function automatic logic [7:0] lane(input logic [31:0] d, input logic [3:0] be,
                                        input logic [7:0] old);
      lane = be[0] ? d[7:0] : old;
   endfunction : lane

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || fault_reset_r) begin
         phase_r <= pc_stack_pkg::PHASE_Q1;
      end else begin
         phase_r <= (phase_r == pc_stack_pkg::PHASE_MAX) ? pc_stack_pkg::PHASE_Q1
                                                          : phase_r + 2'h1;
      end
   end
   assign q1 = (phase_r == pc_stack_pkg::PHASE_Q1);

   // Core requests are sampled only in the first phase.
   // push and pop sources
   assign push = q1 && (req_in.op == pc_stack_pkg::OP_CALL ||
                        req_in.op == pc_stack_pkg::OP_RELATIVE_CALL ||
                        req_in.op == pc_stack_pkg::OP_INT_HIGH ||
                        req_in.op == pc_stack_pkg::OP_INT_LOW ||
                        req_in.op == pc_stack_pkg::OP_PUSH);
   assign pop_ret = q1 && (req_in.op == pc_stack_pkg::OP_RETURN ||
                           req_in.op == pc_stack_pkg::OP_RETURN_WITH_LITERAL ||
                           req_in.op == pc_stack_pkg::OP_RETURN_FROM_INTERRUPT);
   assign pop_discard = q1 && (req_in.op == pc_stack_pkg::OP_POP);
   assign hw_ptr_op = push || pop_ret || pop_discard;

   // Writes land on the accepting edge, where waitrequest is already low.
   assign wr_go = avs_write_in && bus_ack_r;
   assign rd_go = avs_read_in && !bus_ack_r;
   assign pcl_wr = wr_go && avs_address_in == pc_stack_pkg::OFS_PC_LOW && avs_byteenable_in[0];

   assign top_value = read_entry(ptr_r, stack_mem[(ptr_r == pc_stack_pkg::PTR_RESET) ?
                                                  pc_stack_pkg::PTR_ONE : ptr_r]);
   assign stack_is_full = (ptr_r == pc_stack_pkg::PTR_FULL);

   assign push_value = (req_in.op == pc_stack_pkg::OP_PUSH) ? pc_r
                                                             : pc_r + pc_stack_pkg::PC_STEP;

   // Fault reset enable is a configuration bit caught while rst_n_in is low.
   always_ff @(posedge clk_in) begin
      if (!por_n_in) begin
         fault_en_r <= pc_stack_pkg::CONTROL_RESET;
      end else if (wr_go && avs_address_in == pc_stack_pkg::OFS_CONTROL && avs_byteenable_in[0]) begin
         fault_en_r <= avs_writedata_in[pc_stack_pkg::BIT_FAULT_RST];
      end else if (!rst_n_in) begin
         fault_en_r <= fault_cfg_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || fault_reset_r) begin
         ptr_r <= pc_stack_pkg::PTR_RESET;
      end else begin
         ptr_r <= ptr_nxt;
      end
   end

   always_comb begin
      ptr_nxt = ptr_r;
      if (push) begin
         if (!stack_is_full) begin
            ptr_nxt = ptr_r + pc_stack_pkg::PTR_ONE;
         end
      end else if (pop_ret || pop_discard) begin
         if (ptr_r != pc_stack_pkg::PTR_RESET) begin
            ptr_nxt = ptr_r - pc_stack_pkg::PTR_ONE;
         end
      end else if (wr_go && avs_address_in == pc_stack_pkg::OFS_STACK_PTR &&
                   avs_byteenable_in[0]) begin
         ptr_nxt = avs_writedata_in[4:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (push && !stack_is_full) begin
         stack_mem[ptr_r + pc_stack_pkg::PTR_ONE] <= push_value;
      end else if (!hw_ptr_op && wr_go && ptr_r != pc_stack_pkg::PTR_RESET) begin
         if (avs_address_in == pc_stack_pkg::OFS_TOP_LOW && avs_byteenable_in[0]) begin
            stack_mem[ptr_r] <= {top_value[20:8], avs_writedata_in[7:0]};
         end else if (avs_address_in == pc_stack_pkg::OFS_TOP_HIGH && avs_byteenable_in[0]) begin
            stack_mem[ptr_r] <= {top_value[20:16], avs_writedata_in[7:0], top_value[7:0]};
         end else if (avs_address_in == pc_stack_pkg::OFS_TOP_UPPER && avs_byteenable_in[0]) begin
            stack_mem[ptr_r] <= {avs_writedata_in[4:0], top_value[15:0]};
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!por_n_in) begin
         full_r      <= 1'b0;
         underflow_r <= 1'b0;
      end else begin
         if (push && ptr_r == pc_stack_pkg::PTR_FULL - pc_stack_pkg::PTR_ONE) begin
            full_r <= 1'b1;
         end else if (push && stack_is_full) begin
            full_r <= 1'b1;
         end else if (wr_go && avs_address_in == pc_stack_pkg::OFS_STACK_PTR &&
                      avs_byteenable_in[0] && !avs_writedata_in[pc_stack_pkg::BIT_FULL]) begin
            full_r <= 1'b0;
         end
         if ((pop_ret || pop_discard) && ptr_r == pc_stack_pkg::PTR_RESET) begin
            underflow_r <= 1'b1;
         end else if (wr_go && avs_address_in == pc_stack_pkg::OFS_STACK_PTR &&
                      avs_byteenable_in[0] && !avs_writedata_in[pc_stack_pkg::BIT_UNDERFLOW]) begin
            underflow_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || fault_reset_r) begin
         fault_reset_r <= 1'b0;
      end else begin
         fault_reset_r <= fault_en_r &&
                          ((push && ptr_r == pc_stack_pkg::PTR_FULL - pc_stack_pkg::PTR_ONE) ||
                           ((pop_ret || pop_discard) && ptr_r == pc_stack_pkg::PTR_RESET));
      end
   end
   assign stack_reset_out = fault_reset_r;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || fault_reset_r) begin
         pc_r <= pc_stack_pkg::RESET_VECTOR;
      end else if (q1) begin
         case (req_in.op)
            pc_stack_pkg::OP_INT_HIGH: pc_r <= pc_stack_pkg::HIGH_VECTOR;
            pc_stack_pkg::OP_INT_LOW:  pc_r <= pc_stack_pkg::LOW_VECTOR;
            pc_stack_pkg::OP_CALL,
            pc_stack_pkg::OP_RELATIVE_CALL,
            pc_stack_pkg::OP_GOTO:     pc_r <= {req_in.target[20:1], 1'b0};
            pc_stack_pkg::OP_RETURN,
            pc_stack_pkg::OP_RETURN_WITH_LITERAL,
            pc_stack_pkg::OP_RETURN_FROM_INTERRUPT:   pc_r <= {top_value[20:1], 1'b0};
            // first-phase increment
            // A low byte write in the first phase replaces the step here, but is lost under a call, goto, return or interrupt op.
            default:                   pc_r <= pcl_wr ?
                                               {upper_latch_r, high_latch_r,
                                                avs_writedata_in[7:1], 1'b0} :
                                               pc_r + pc_stack_pkg::PC_STEP;
         endcase
      end else if (pcl_wr) begin
         pc_r <= {upper_latch_r, high_latch_r, avs_writedata_in[7:1], 1'b0};
      end
   end

   // latches untouched by calls and returns
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         high_latch_r  <= 8'h00;
         upper_latch_r <= 5'h00;
      end else if (rd_go && avs_address_in == pc_stack_pkg::OFS_PC_LOW) begin
         high_latch_r  <= pc_r[15:8];
         upper_latch_r <= pc_r[20:16];
      end else if (wr_go && avs_address_in == pc_stack_pkg::OFS_PC_HIGH_LAT) begin
         high_latch_r  <= lane(avs_writedata_in, avs_byteenable_in, high_latch_r);
      end else if (wr_go && avs_address_in == pc_stack_pkg::OFS_PC_UPPER_LAT &&
                   avs_byteenable_in[0]) begin
         upper_latch_r <= avs_writedata_in[4:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         shadow_r <= '0;
      end else if (q1 && (req_in.op == pc_stack_pkg::OP_INT_HIGH ||
                          req_in.op == pc_stack_pkg::OP_INT_LOW ||
                          (req_in.op == pc_stack_pkg::OP_CALL && req_in.fast))) begin
         shadow_r <= regs_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         fast_restore_out <= 1'b0;
         fast_regs_out    <= '0;
      end else begin
         fast_restore_out <= pop_ret && req_in.fast &&
                             (req_in.op == pc_stack_pkg::OP_RETURN ||
                              req_in.op == pc_stack_pkg::OP_RETURN_FROM_INTERRUPT);
         fast_regs_out    <= shadow_r;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         fetch_word_out <= 16'h0000;
         phase_q1_out   <= 1'b0;
         pc_out         <= pc_stack_pkg::RESET_VECTOR;
      end else begin
         fetch_word_out <= (32'(pc_r) < 32'(MEM_BYTES)) ? fetch_word_in : 16'h0000;
         phase_q1_out   <= q1;
         pc_out         <= pc_r;
      end
   end

   // Every access takes exactly one wait cycle, which keeps reads registered.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         bus_ack_r        <= 1'b0;
         avs_readdata_out <= 32'h00000000;
      end else begin
         bus_ack_r <= (avs_read_in || avs_write_in) && !bus_ack_r;
         if (rd_go) begin
            case (avs_address_in)
               pc_stack_pkg::OFS_STACK_PTR:    avs_readdata_out <= {24'h000000, full_r,
                                                                     underflow_r, 1'b0, ptr_r};
               pc_stack_pkg::OFS_TOP_LOW:      avs_readdata_out <= {24'h000000, top_value[7:0]};
               pc_stack_pkg::OFS_TOP_HIGH:     avs_readdata_out <= {24'h000000, top_value[15:8]};
               pc_stack_pkg::OFS_TOP_UPPER:    avs_readdata_out <= {27'h0000000, top_value[20:16]};
               pc_stack_pkg::OFS_PC_LOW:       avs_readdata_out <= {24'h000000, pc_r[7:0]};
               pc_stack_pkg::OFS_PC_HIGH_LAT:  avs_readdata_out <= {24'h000000, high_latch_r};
               pc_stack_pkg::OFS_PC_UPPER_LAT: avs_readdata_out <= {27'h0000000, upper_latch_r};
               pc_stack_pkg::OFS_CONTROL:      avs_readdata_out <= {31'h00000000, fault_en_r};
               pc_stack_pkg::OFS_PC_FULL:      avs_readdata_out <= {11'h000, pc_r};
               default:                        avs_readdata_out <= 32'h00000000;
            endcase
         end
      end
   end
   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !bus_ack_r;

endmodule : pc_and_return_stack
`default_nettype wire

// >>> pc_stack_checker.sv
// Concurrent checks on the ports of the program counter and return stack block.
`timescale 1ns/1ps
`default_nettype none
module pc_stack_checker #(
   parameter int MEM_BYTES = 8192
) (
   input wire logic                     clk_in,
   input wire logic                     rst_n_in,
   input wire pc_stack_pkg::core_req_t  req_in,
   input wire pc_stack_pkg::fast_regs_t regs_in,
   input wire logic                     avs_read_in,
   input wire logic                     avs_write_in,
   input wire logic                     avs_waitrequest_out,
   input wire logic [20:0]              pc_out,
   input wire logic [15:0]              fetch_word_out,
   input wire logic                     phase_q1_out,
   input wire logic                     fast_restore_out,
   input wire pc_stack_pkg::fast_regs_t fast_regs_out,
   input wire logic                     stack_reset_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // The phase marker follows the sampling edge, so $past(req_in) is the operation just taken.
   property p_goto_direct;
      phase_q1_out && $past(req_in.op) == pc_stack_pkg::OP_GOTO
         |=> pc_out == $past(req_in.target, 2);
   endproperty
   a_goto_direct: assert property (p_goto_direct) else $error("goto target not loaded");
   property p_vec_high;
      phase_q1_out && $past(req_in.op) == pc_stack_pkg::OP_INT_HIGH
         |=> pc_out == pc_stack_pkg::HIGH_VECTOR;
   endproperty
   a_vec_high: assert property (p_vec_high) else $error("high vector not loaded");
   property p_vec_low;
      phase_q1_out && $past(req_in.op) == pc_stack_pkg::OP_INT_LOW
         |=> pc_out == pc_stack_pkg::LOW_VECTOR;
   endproperty
   a_vec_low: assert property (p_vec_low) else $error("low vector not loaded");
   property p_shadow_int;
      phase_q1_out && $past(req_in.op) inside {pc_stack_pkg::OP_INT_HIGH, pc_stack_pkg::OP_INT_LOW}
         |-> ##[0:2] fast_regs_out == regs_in;
   endproperty
   a_shadow_int: assert property (p_shadow_int) else $error("shadow not loaded");
   property p_fast_restore;
      phase_q1_out && $past(req_in.fast)
         && $past(req_in.op) inside {pc_stack_pkg::OP_RETURN, pc_stack_pkg::OP_RETURN_FROM_INTERRUPT}
         |-> fast_restore_out;
   endproperty
   a_fast_restore: assert property (p_fast_restore) else $error("no fast restore");
   property p_fault_pulse;
      stack_reset_out |=> !stack_reset_out;
   endproperty
   a_fault_pulse: assert property (p_fault_pulse) else $error("fault reset too long");
   property p_bus_wait;
      $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
   endproperty
   a_bus_wait: assert property (p_bus_wait) else $error("wait cycle count wrong");
   property p_fetch_zero;
      $stable(pc_out) && pc_out >= MEM_BYTES |-> fetch_word_out == 16'h0000;
   endproperty
   a_fetch_zero: assert property (p_fetch_zero) else $error("fetch beyond memory");
   property p_pc_even;
      pc_out[0] == 1'b0;
   endproperty
   a_pc_even: assert property (p_pc_even) else $error("counter odd");
endmodule : pc_stack_checker
bind pc_and_return_stack pc_stack_checker #(.MEM_BYTES(MEM_BYTES)) u_pc_stack_checker (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req_in), .regs_in(regs_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_waitrequest_out(avs_waitrequest_out), .pc_out(pc_out),
   .fetch_word_out(fetch_word_out), .phase_q1_out(phase_q1_out),
   .fast_restore_out(fast_restore_out), .fast_regs_out(fast_regs_out),
   .stack_reset_out(stack_reset_out)
);
`default_nettype wire

// >>> core_model.sv
// Behavioural instruction decoder that presents queued core operations.
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input  wire logic               clk_in,
   input  wire logic               phase_in,
   output pc_stack_pkg::core_req_t req_out
);
   localparam pc_stack_pkg::core_req_t REQ_IDLE = '{op: pc_stack_pkg::OP_NONE, fast: 1'b0,
                                                    target: 21'h000000};
   pc_stack_pkg::core_req_t pend_q[$];
   initial req_out = REQ_IDLE;
   task automatic issue(input pc_stack_pkg::core_op_t op, input logic f, input logic [20:0] t);
      pend_q.push_back('{op: op, fast: f, target: t});
   endtask : issue
   // one op per four-phase instruction cycle
   // Changing only after the phase marker keeps each op steady across one sampling edge.
   always @(posedge clk_in) begin
      if (phase_in === 1'b1) begin
         req_out <= (pend_q.size() != 0) ? pend_q.pop_front() : REQ_IDLE;
      end
   end
endmodule : core_model
`default_nettype wire

// >>> test_pc_and_return_stack.sv
// Self-checking bench for the program counter and return stack.
`timescale 1ns/1ps
`default_nettype none
module test_pc_and_return_stack;
   logic                     clk_in   = 1'b0;
   logic                     rst_n_in = 1'b0;
   logic                     por_n_in = 1'b0;
   logic                     fault_in = 1'b0;
   pc_stack_pkg::fast_regs_t regs_in  = '0;
   logic [15:0]              fetch_in = 16'h0000;
   logic [3:0]               addr     = 4'h0;
   logic                     rd_en    = 1'b0;
   logic                     wr_en    = 1'b0;
   logic [31:0]              wdata    = 32'h00000000;
   pc_stack_pkg::core_req_t  req;
   pc_stack_pkg::fast_regs_t shadow, s1, s2, s3;
   logic [31:0]              rdata;
   logic [20:0]              pc;
   logic [15:0]              fetch_out;
   logic [12:0]              v;
   logic [63:0]              e;
   logic                     wait_req, q1, restore, stk_rst;
   logic [63:0]              exp_q[$];
   int                       error_cnt = 0;
   int                       cmp_count = 0;
   int                       cyc = 0;
   int                       rst_cnt = 0;
   int                       seed = 64;
   pc_and_return_stack u_pc_and_return_stack (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in), .fault_cfg_in(fault_in),
      .req_in(req), .regs_in(regs_in), .fetch_word_in(fetch_in), .avs_address_in(addr),
      .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
      .pc_out(pc), .fetch_word_out(fetch_out), .phase_q1_out(q1),
      .fast_restore_out(restore), .fast_regs_out(shadow), .stack_reset_out(stk_rst)
   );
   core_model u_core_model (.clk_in(clk_in), .phase_in(q1), .req_out(req));
   initial begin
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic test_done;
      if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      logic ws;
      addr  <= a;
      wdata <= d;
      wr_en <= w;
      rd_en <= ~w;
      // Waitrequest is taken settled before the edge that it qualifies.
      do begin
         @(negedge clk_in);
         ws = wait_req;
         @(posedge clk_in);
      end while (ws !== 1'b0);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge clk_in);
   endtask : bus
   task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m = '1);
      exp_q.push_back({m, x & m});
      bus(1'b0, a, 32'h0);
   endtask : rd
   task automatic put(input pc_stack_pkg::core_op_t op, input logic f, input logic [20:0] t);
      u_core_model.issue(op, f, t);
   endtask : put
   // Polled on the falling edge so the model's queue and request have settled.
   task automatic run;
      do @(negedge clk_in);
      while (u_core_model.pend_q.size() != 0 || req.op != pc_stack_pkg::OP_NONE);
      repeat (3) @(posedge clk_in);
   endtask : run
   task automatic do_reset(input logic p);
      rst_n_in <= 1'b0;
      por_n_in <= ~p;
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      por_n_in <= 1'b1;
      @(posedge clk_in);
   endtask : do_reset
   always @(posedge clk_in) begin
      fetch_in <= 16'($random(seed));
      cyc++;
      if (stk_rst === 1'b1) rst_cnt++;
      if (rd_en === 1'b1 && wait_req === 1'b0 && exp_q.size() != 0) begin
         e = exp_q.pop_front();
         check(rdata & e[63:32], e[31:0]);
      end
      if (cyc == 8000) begin
         error_cnt++;
         test_done();
      end
   end
   initial begin
      do_reset(1'b1);
      rd(4'h0, 32'h0);
      rd(4'h9, 32'h0);
      rd(4'hf, 32'h0);
      bus(1'b1, 4'h7, 32'h0);
      put(pc_stack_pkg::OP_GOTO, 1'b0, 21'h000100);
      put(pc_stack_pkg::OP_CALL, 1'b0, 21'h000400);
      run();
      rd(4'h0, 32'h1);
      rd(4'h1, 32'h02);
      rd(4'h2, 32'h01);
      rd(4'h3, 32'h00);
      v = 13'($random(seed));
      bus(1'b1, 4'h1, 32'h0);
      bus(1'b1, 4'h2, {24'h0, v[7:0]});
      bus(1'b1, 4'h3, {27'h0, v[12:8]});
      put(pc_stack_pkg::OP_RETURN, 1'b0, 21'h0);
      run();
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h0, 32'h0);
      rd(4'h5, {24'h0, v[7:0]});
      rd(4'h6, {27'h0, v[12:8]});
      put(pc_stack_pkg::OP_RETURN, 1'b0, 21'h0);
      run();
      rd(4'h0, 32'h40);
      rd(4'h4, 32'h0, 32'h0);
      rd(4'h5, 32'h0);
      bus(1'b1, 4'h0, 32'h0);
      rd(4'h0, 32'h0);
      bus(1'b1, 4'h5, 32'h5a);
      bus(1'b1, 4'h6, 32'h03);
      put(pc_stack_pkg::OP_CALL, 1'b0, 21'h000300);
      put(pc_stack_pkg::OP_RETURN_WITH_LITERAL, 1'b0, 21'h0);
      put(pc_stack_pkg::OP_GOTO, 1'b0, 21'h000600);
      run();
      rd(4'h5, 32'h5a);
      rd(4'h6, 32'h03);
      bus(1'b1, 4'h4, 32'h40);
      bus(1'b1, 4'h5, 32'h11);
      bus(1'b1, 4'h6, 32'h01);
      rd(4'h4, 32'h0, 32'h0);
      rd(4'h5, 32'h5a);
      rd(4'h6, 32'h03);
      check({16'h0, fetch_out}, 32'h0);
      s1 = 24'($random(seed));
      regs_in <= s1;
      put(pc_stack_pkg::OP_INT_HIGH, 1'b0, 21'h0);
      run();
      check({8'h0, shadow}, {8'h0, s1});
      s2 = 24'($random(seed));
      regs_in <= s2;
      put(pc_stack_pkg::OP_INT_LOW, 1'b0, 21'h0);
      run();
      check({8'h0, shadow}, {8'h0, s2});
      rd(4'h0, 32'h2);
      put(pc_stack_pkg::OP_RETURN_FROM_INTERRUPT, 1'b1, 21'h0);
      s3 = 24'($random(seed));
      regs_in <= s3;
      put(pc_stack_pkg::OP_CALL, 1'b0, 21'h000700);
      run();
      check({8'h0, shadow}, {8'h0, s2});
      put(pc_stack_pkg::OP_CALL, 1'b1, 21'h000700);
      run();
      check({8'h0, shadow}, {8'h0, s3});
      put(pc_stack_pkg::OP_RETURN, 1'b1, 21'h0);
      put(pc_stack_pkg::OP_RETURN, 1'b0, 21'h0);
      put(pc_stack_pkg::OP_PUSH, 1'b0, 21'h0);
      run();
      rd(4'h0, 32'h2);
      put(pc_stack_pkg::OP_POP, 1'b0, 21'h0);
      run();
      rd(4'h0, 32'h1);
      bus(1'b1, 4'h0, 32'd29);
      put(pc_stack_pkg::OP_GOTO, 1'b0, 21'h000200);
      put(pc_stack_pkg::OP_CALL, 1'b0, 21'h000800);
      put(pc_stack_pkg::OP_CALL, 1'b0, 21'h000a00);
      put(pc_stack_pkg::OP_CALL, 1'b0, 21'h000c00);
      run();
      rd(4'h0, 32'h9f);
      rd(4'h1, 32'h02);
      rd(4'h2, 32'h08);
      put(pc_stack_pkg::OP_POP, 1'b0, 21'h0);
      run();
      rd(4'h0, 32'h9e);
      do_reset(1'b0);
      rd(4'h0, 32'h80);
      do_reset(1'b1);
      rd(4'h0, 32'h0);
      bus(1'b1, 4'h7, 32'h1);
      bus(1'b1, 4'h0, 32'd30);
      put(pc_stack_pkg::OP_CALL, 1'b0, 21'h000200);
      run();
      rd(4'h0, 32'h80);
      bus(1'b1, 4'h0, 32'h0);
      put(pc_stack_pkg::OP_RETURN, 1'b0, 21'h0);
      run();
      rd(4'h0, 32'h40);
      check(32'(rst_cnt), 32'd2);
      repeat (4) @(posedge clk_in);
      test_done();
   end
endmodule : test_pc_and_return_stack
`default_nettype wire
